// ---- src/rxff_top.sv ----
`timescale 1ns/10ps
// Operation
// - Three-bit field picks multicast receive channel.
// - Writing one to set bit enables channel.
// - Zero writes ignored; read returns enable states.
// - Writing one to clear bit disables channel.
// - Set and clear share the same enables.
// - Sixteen-bit max length, resets to 1518.
// - Byte count above maximum means long frame.
// - Long frame without errors is oversized.
// - Long frame with CRC/code/alignment error: jabber.
// - Offset copied into first-buffer descriptor field.
// - Offset bytes skipped; data starts after them.
// - One offset value serves every channel.
// - Multicast delivered only while enable bit set.
module rxff_top
  import rxff_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic frame_end,
  input wire logic [15:0] frame_byte_count,
  input wire logic frame_crc_err,
  input wire logic frame_code_err,
  input wire logic frame_align_err,
  output logic frame_long,
  output logic frame_oversize,
  output logic frame_jabber,
  input wire logic dest_valid,
  input wire logic dest_unicast,
  input wire logic dest_multicast,
  input wire logic [2:0] dest_chan,
  output logic deliver_valid,
  output logic [2:0] deliver_chan,
  output logic deliver_drop,
  input wire logic sop_desc_req,
  output logic sop_desc_valid,
  output logic [15:0] sop_buffer_offset,
  output logic irq
);
  rxff_cfg_if cfg ();

  logic [2:0] multicast_channel_select;
  logic multicast_accept_enable;
  logic [7:0] unicast_enable;
  logic [15:0] max_frame_length;
  logic [15:0] buffer_start_offset;
  logic [2:0] int_status;
  logic [2:0] int_mask;
  logic [2:0] int_event;

  logic wr_pend;
  logic rd_wait;
  logic [7:0] dp_addr;
  logic addr_ok;
  logic wr_hit;
  logic [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes commit at the end of a zero-wait data phase.
  // Reads take one wait state so that hrdata comes from a flip-flop and
  // always reflects a write that finished just before.

  assign addr_ok = hsel & hready & (htrans == rxff_htrans_nonseq);
  assign hreadyout = ~rd_wait;
  assign hresp = 1'b0;
  assign wr_hit = wr_pend;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_wait <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      rd_wait <= addr_ok & ~hwrite;
      wr_pend <= addr_ok & hwrite;
      if (addr_ok) begin
        dp_addr <= haddr[7:0];
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (dp_addr)
      rxff_off_group: begin
        rd_mux[rxff_mc_chan_lsb +: 3] = multicast_channel_select;
        rd_mux[rxff_mc_en_bit] = multicast_accept_enable;
      end
      rxff_off_uc_set: rd_mux[7:0] = unicast_enable;
      rxff_off_uc_clr: rd_mux[7:0] = unicast_enable;
      rxff_off_max_len: rd_mux[15:0] = max_frame_length;
      rxff_off_buf_off: rd_mux[15:0] = buffer_start_offset;
      rxff_off_int_stat: rd_mux[2:0] = int_status;
      rxff_off_int_mask: rd_mux[2:0] = int_mask;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_wait) begin
      hrdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      multicast_channel_select <= rxff_mc_chan_rst;
      multicast_accept_enable <= 1'b0;
    end else if (wr_hit && dp_addr == rxff_off_group) begin
      multicast_channel_select <= hwdata[rxff_mc_chan_lsb +: 3];
      multicast_accept_enable <= hwdata[rxff_mc_en_bit];
    end
  end

  // Both the set and the clear address act on one enable vector.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unicast_enable <= rxff_uc_en_rst;
    end else if (wr_hit && dp_addr == rxff_off_uc_set) begin
      unicast_enable <= unicast_enable | hwdata[7:0];
    end else if (wr_hit && dp_addr == rxff_off_uc_clr) begin
      unicast_enable <= unicast_enable & ~hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      max_frame_length <= rxff_max_len_rst;
    end else if (wr_hit && dp_addr == rxff_off_max_len) begin
      max_frame_length <= hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buffer_start_offset <= rxff_buf_off_rst;
    end else if (wr_hit && dp_addr == rxff_off_buf_off) begin
      buffer_start_offset <= hwdata[15:0];
    end
  end

  assign cfg.multicast_channel_select = multicast_channel_select;
  assign cfg.multicast_accept_enable = multicast_accept_enable;
  assign cfg.unicast_enable = unicast_enable;
  assign cfg.max_frame_length = max_frame_length;

  ////////////////////////////////////////////////////////////////////////////
  // Start-of-packet descriptor offset. There is a single offset for all
  // channels, so the request carries no channel number. The descriptor
  // engine skips this many leading bytes before writing frame data.

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sop_desc_valid <= 1'b0;
      sop_buffer_offset <= 16'h0000;
    end else begin
      sop_desc_valid <= sop_desc_req;
      if (sop_desc_req) begin
        sop_buffer_offset <= buffer_start_offset;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame classification and delivery.

  rxff_classify u_classify (
    .hclk(hclk),
    .hresetn(hresetn),
    .cfg(cfg.classify),
    .frame_end(frame_end),
    .frame_byte_count(frame_byte_count),
    .frame_crc_err(frame_crc_err),
    .frame_code_err(frame_code_err),
    .frame_align_err(frame_align_err),
    .frame_long(frame_long),
    .frame_oversize(frame_oversize),
    .frame_jabber(frame_jabber)
  );

  rxff_route u_route (
    .hclk(hclk),
    .hresetn(hresetn),
    .cfg(cfg.route),
    .dest_valid(dest_valid),
    .dest_unicast(dest_unicast),
    .dest_multicast(dest_multicast),
    .dest_chan(dest_chan),
    .deliver_valid(deliver_valid),
    .deliver_chan(deliver_chan),
    .deliver_drop(deliver_drop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts. A new event in the cycle of a write-one-to-clear wins, so
  // no event is lost to a racing clear.

  always_comb begin
    int_event = 3'h0;
    int_event[rxff_int_oversize] = frame_oversize;
    int_event[rxff_int_jabber] = frame_jabber;
    int_event[rxff_int_drop] = deliver_drop;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_status <= 3'h0;
    end else if (wr_hit && dp_addr == rxff_off_int_stat) begin
      int_status <= (int_status & ~hwdata[2:0]) | int_event;
    end else begin
      int_status <= int_status | int_event;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_mask <= 3'h0;
    end else if (wr_hit && dp_addr == rxff_off_int_mask) begin
      int_mask <= hwdata[2:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_status & int_mask);
    end
  end
endmodule : rxff_top

// ---- src/rxff_pkg.sv ----
package rxff_pkg;
  localparam int rxff_num_chan = 8;
  localparam int rxff_chan_w = 3;
  localparam int rxff_len_w = 16;
  localparam int rxff_int_w = 3;

  localparam logic [7:0] rxff_off_group = 8'h00;
  localparam logic [7:0] rxff_off_uc_set = 8'h04;
  localparam logic [7:0] rxff_off_uc_clr = 8'h08;
  localparam logic [7:0] rxff_off_max_len = 8'h0c;
  localparam logic [7:0] rxff_off_buf_off = 8'h10;
  localparam logic [7:0] rxff_off_int_stat = 8'h14;
  localparam logic [7:0] rxff_off_int_mask = 8'h18;

  localparam int rxff_mc_chan_lsb = 0;
  localparam int rxff_mc_en_bit = 5;

  localparam int rxff_int_oversize = 0;
  localparam int rxff_int_jabber = 1;
  localparam int rxff_int_drop = 2;

  localparam logic [15:0] rxff_max_len_rst = 16'h05ee;
  localparam logic [15:0] rxff_buf_off_rst = 16'h0000;
  localparam logic [7:0] rxff_uc_en_rst = 8'h00;
  localparam logic [2:0] rxff_mc_chan_rst = 3'h0;

  localparam logic [1:0] rxff_htrans_nonseq = 2'h2;
  localparam logic [2:0] rxff_hsize_word = 3'h2;
endpackage : rxff_pkg

// ---- src/rxff_cfg_if.sv ----
`timescale 1ns/10ps
interface rxff_cfg_if;
  logic [2:0] multicast_channel_select;
  logic multicast_accept_enable;
  logic [7:0] unicast_enable;
  logic [15:0] max_frame_length;

  modport regs (
    output multicast_channel_select,
    output multicast_accept_enable,
    output unicast_enable,
    output max_frame_length
  );
  modport classify (
    input max_frame_length
  );
  modport route (
    input multicast_channel_select,
    input multicast_accept_enable,
    input unicast_enable
  );
endinterface : rxff_cfg_if

// ---- src/rxff_classify.sv ----
`timescale 1ns/10ps
module rxff_classify
  import rxff_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  rxff_cfg_if.classify cfg,
  input wire logic frame_end,
  input wire logic [15:0] frame_byte_count,
  input wire logic frame_crc_err,
  input wire logic frame_code_err,
  input wire logic frame_align_err,
  output logic frame_long,
  output logic frame_oversize,
  output logic frame_jabber
);
  logic is_long;
  logic has_err;

  assign is_long = frame_byte_count > cfg.max_frame_length;
  assign has_err = frame_crc_err | frame_code_err | frame_align_err;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_long <= 1'b0;
      frame_oversize <= 1'b0;
      frame_jabber <= 1'b0;
    end else begin
      frame_long <= frame_end & is_long;
      frame_oversize <= frame_end & is_long & ~has_err;
      frame_jabber <= frame_end & is_long & has_err;
    end
  end
endmodule : rxff_classify

// ---- src/rxff_route.sv ----
`timescale 1ns/10ps
module rxff_route
  import rxff_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  rxff_cfg_if.route cfg,
  input wire logic dest_valid,
  input wire logic dest_unicast,
  input wire logic dest_multicast,
  input wire logic [2:0] dest_chan,
  output logic deliver_valid,
  output logic [2:0] deliver_chan,
  output logic deliver_drop
);
  logic uc_ok;
  logic mc_ok;

  // A frame marked multicast follows the multicast setting alone, so a cleared
  // multicast enable cannot be bypassed through the unicast path.
  assign uc_ok = dest_unicast & ~dest_multicast & cfg.unicast_enable[dest_chan];
  assign mc_ok = dest_multicast & cfg.multicast_accept_enable;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      deliver_valid <= 1'b0;
      deliver_drop <= 1'b0;
    end else begin
      deliver_valid <= dest_valid & (uc_ok | mc_ok);
      deliver_drop <= dest_valid & ~(uc_ok | mc_ok);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      deliver_chan <= 3'h0;
    end else if (dest_valid) begin
      // Multicast goes only to the selected channel, never the address's own.
      deliver_chan <= mc_ok ? cfg.multicast_channel_select : dest_chan;
    end
  end
endmodule : rxff_route

// ---- dv/rxff_top_props.sv ----
`timescale 1ns/10ps
module rxff_top_props
  import rxff_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic frame_end,
  input wire logic [15:0] frame_byte_count,
  input wire logic frame_crc_err,
  input wire logic frame_code_err,
  input wire logic frame_align_err,
  input wire logic frame_long,
  input wire logic frame_oversize,
  input wire logic frame_jabber,
  input wire logic dest_valid,
  input wire logic dest_unicast,
  input wire logic dest_multicast,
  input wire logic [2:0] dest_chan,
  input wire logic deliver_valid,
  input wire logic [2:0] deliver_chan,
  input wire logic deliver_drop,
  input wire logic sop_desc_req,
  input wire logic sop_desc_valid
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_long_cause: assert property (frame_long |-> $past(frame_end)) else $error("long flag without frame end");
  a_zero_short: assert property (frame_end && frame_byte_count == 16'h0000 |=> !frame_long)
    else $error("empty frame flagged long");
  a_oversize_clean: assert property (frame_end && !(frame_crc_err || frame_code_err || frame_align_err)
    |=> frame_oversize == frame_long && !frame_jabber) else $error("oversize class wrong");
  a_jabber_error: assert property (frame_end && (frame_crc_err || frame_code_err || frame_align_err)
    |=> frame_jabber == frame_long && !frame_oversize) else $error("jabber class wrong");
  a_deliver_once: assert property (dest_valid |=> deliver_valid != deliver_drop) else $error("no single verdict");
  a_deliver_quiet: assert property (!dest_valid |=> !deliver_valid && !deliver_drop)
    else $error("verdict without request");
  a_unicast_chan: assert property (dest_valid && dest_unicast && !dest_multicast
    |=> !deliver_valid || deliver_chan == $past(dest_chan)) else $error("unicast channel wrong");
  a_offset_answer: assert property (sop_desc_req |=> sop_desc_valid) else $error("offset not answered");
  a_offset_cause: assert property (sop_desc_valid |-> $past(sop_desc_req)) else $error("offset without request");
  a_read_wait: assert property (hsel && hready && htrans == 2'h2 && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait cycle wrong");
  a_resp_okay: assert property (hresp == 1'b0) else $error("bus response not okay");
endmodule : rxff_top_props

// ---- dv/test_rxff_top.sv ----
`timescale 1ns/10ps
module test_rxff_top import rxff_pkg::*;;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, frame_end, frame_crc_err, frame_code_err;
  logic frame_align_err, frame_long, frame_oversize, frame_jabber, dest_valid, dest_unicast, dest_multicast;
  logic deliver_valid, deliver_drop, sop_desc_req, sop_desc_valid, irq, mc_en;
  logic [31:0] haddr, hwdata, hrdata, q, d, r;
  logic [1:0] htrans;
  logic [2:0] hsize, dest_chan, deliver_chan, mc_sel;
  logic [15:0] frame_byte_count, sop_buffer_offset, max_len;
  logic [7:0] uc_en;
  int miscompares = 0;
  int check_count = 0;
  int cyc = 0;
  // Single slave, so its ready is the bus ready.
  assign hready = hreadyout;
  rxff_top rxff_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
    .hresp, .hrdata, .frame_end, .frame_byte_count, .frame_crc_err, .frame_code_err, .frame_align_err,
    .frame_long, .frame_oversize, .frame_jabber, .dest_valid, .dest_unicast, .dest_multicast, .dest_chan,
    .deliver_valid, .deliver_chan, .deliver_drop, .sop_desc_req, .sop_desc_valid, .sop_buffer_offset, .irq);
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task final_report;
    $display("checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  // Ready and read data are taken at the rising edge itself; every change follows that edge.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= {24'h000000, a}; htrans <= rxff_htrans_nonseq; hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  function logic [2:0] cls(input logic [15:0] n, input logic [2:0] e);
    cls = {n > max_len, n > max_len && e == 3'h0, n > max_len && e != 3'h0};
  endfunction : cls
  task frame(input logic [15:0] n, input logic [2:0] e);
    @(posedge hclk);
    frame_end <= 1'b1; frame_byte_count <= n; {frame_crc_err, frame_code_err, frame_align_err} <= e;
    @(posedge hclk);
    frame_end <= 1'b0;
    #1;
    chk({frame_long, frame_oversize, frame_jabber}, cls(n, e));
  endtask : frame
  task route(input logic uc, input logic mc, input logic [2:0] ch);
    logic v;
    v = mc ? mc_en : uc_en[ch];
    @(posedge hclk);
    dest_valid <= 1'b1; dest_unicast <= uc; dest_multicast <= mc; dest_chan <= ch;
    @(posedge hclk);
    dest_valid <= 1'b0;
    #1;
    chk({deliver_valid, deliver_drop}, {v, !v});
    if (v) chk(deliver_chan, mc ? mc_sel : ch);
  endtask : route
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = rxff_hsize_word;
    hwdata = 32'h0; frame_end = 1'b0; frame_byte_count = 16'h0; frame_crc_err = 1'b0; frame_code_err = 1'b0;
    frame_align_err = 1'b0; dest_valid = 1'b0; dest_unicast = 1'b0; dest_multicast = 1'b0; dest_chan = 3'h0;
    sop_desc_req = 1'b0; uc_en = 8'h00; max_len = 16'h05ee;
    void'($urandom(32'hb774));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rd(rxff_off_group, 32'h0);
    rd(rxff_off_uc_set, 32'h0);
    rd(rxff_off_max_len, 32'h5ee);
    rd(rxff_off_buf_off, 32'h0);
    rd(8'h1c, 32'h0);
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      d = $urandom; d[2:0] = i[2:0]; d[5] = i[0]; mc_en = d[5]; mc_sel = i[2:0]; r = $urandom;
      bus(1'b1, rxff_off_group, d);
      rd(rxff_off_group, d & 32'h27);
      route(r[0], 1'b1, r[3:1]);
    end
    $display("multicast done");
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 32'hff : $urandom;
      r = (i == 5) ? 32'hff : $urandom;
      bus(1'b1, rxff_off_uc_set, d);
      uc_en = uc_en | d[7:0];
      rd(rxff_off_uc_set, {24'h0, uc_en});
      bus(1'b1, rxff_off_uc_clr, r);
      uc_en = uc_en & ~r[7:0];
      rd(rxff_off_uc_clr, {24'h0, uc_en});
      for (int c = 0; c < 8; c++) route(1'b1, 1'b0, c[2:0]);
    end
    bus(1'b1, rxff_off_uc_set, 32'h0000_00ff);
    uc_en = 8'hff; mc_en = 1'b0; mc_sel = 3'h3;
    bus(1'b1, rxff_off_group, 32'h0000_0003);
    route(1'b1, 1'b1, 3'h6);
    mc_en = 1'b1; mc_sel = 3'h4;
    bus(1'b1, rxff_off_group, 32'h0000_0024);
    route(1'b1, 1'b1, 3'h6);
    $display("unicast done");
    frame(16'h05ee, 3'h0);
    for (int e = 0; e < 8; e++) frame(16'h05ef, e[2:0]);
    for (int i = 0; i < 4; i++) begin
      d = $urandom; r = $urandom; max_len = d[15:0];
      bus(1'b1, rxff_off_max_len, d);
      rd(rxff_off_max_len, d & 32'hffff);
      frame(max_len, r[2:0]);
      frame(max_len + 16'h1, r[5:3]);
    end
    $display("length classes done");
    max_len = 16'h0064;
    bus(1'b1, rxff_off_max_len, 32'h0000_0064);
    bus(1'b1, rxff_off_int_mask, 32'h0);
    bus(1'b1, rxff_off_int_stat, 32'h7);
    frame(16'h00c8, 3'h0);
    rd(rxff_off_int_stat, 32'h1);
    chk(irq, 1'b0);
    bus(1'b1, rxff_off_int_mask, 32'h3);
    repeat (2) @(negedge hclk);
    chk(irq, 1'b1);
    frame(16'h00c8, 3'h2);
    rd(rxff_off_int_stat, 32'h3);
    bus(1'b1, rxff_off_int_stat, 32'h3);
    repeat (2) @(negedge hclk);
    chk(irq, 1'b0);
    $display("interrupt done");
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 32'h0 : (i == 1) ? 32'hf : $urandom;
      bus(1'b1, rxff_off_buf_off, d);
      rd(rxff_off_buf_off, d & 32'hffff);
      @(posedge hclk);
      sop_desc_req <= 1'b1;
      @(posedge hclk);
      sop_desc_req <= 1'b0;
      #1;
      chk({sop_desc_valid, sop_buffer_offset}, {1'b1, d[15:0]});
    end
    $display("buffer offset done");
    final_report();
  end
endmodule : test_rxff_top
bind rxff_top rxff_top_props rxff_top_props_i (.hclk, .hresetn, .hsel, .hready, .htrans, .hwrite, .hreadyout,
  .hresp, .frame_end, .frame_byte_count, .frame_crc_err, .frame_code_err, .frame_align_err, .frame_long,
  .frame_oversize, .frame_jabber, .dest_valid, .dest_unicast, .dest_multicast, .dest_chan, .deliver_valid,
  .deliver_chan, .deliver_drop, .sop_desc_req, .sop_desc_valid);
